// ### rtl/lcd_host_command_pkg.sv
// Constants, command codes and sequencer states of the LCD host command unit.
package lcd_host_command_pkg;

	localparam logic [3:0] CMD_CURSOR_ROW = 4'h4;
	localparam logic [3:0] CMD_START_LOW = 4'h8;
	localparam logic [3:0] CMD_START_HIGH = 4'h9;
	localparam logic [3:0] CMD_CURSOR_LOW = 4'ha;
	localparam logic [3:0] CMD_CURSOR_HIGH = 4'hb;
	localparam logic [3:0] CMD_RAM_WRITE = 4'hc;
	localparam logic [3:0] CMD_RAM_READ = 4'hd;
	localparam logic [3:0] CMD_BIT_CLEAR = 4'he;
	localparam logic [3:0] CMD_BIT_SET = 4'hf;

	localparam int BUSY_BIT_POS = 7;
	localparam int CMD_FIELD_W = 4;
	localparam int ROW_FIELD_W = 4;
	localparam int BIT_INDEX_W = 3;

	// Cycles from the read strobe to the cycle in which read data is sampled.
	localparam logic [1:0] RAM_READ_LAT = 2'h2;

	localparam logic [3:0] RST_COMMAND = 4'h0;
	localparam logic [3:0] RST_CURSOR_ROW = 4'h0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_ADDRESS = 16'h0000;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WRITE,
		ST_READ_WAIT,
		ST_BIT_WAIT,
		ST_BIT_WRITE
	} exec_st_t;

endpackage : lcd_host_command_pkg

// ### rtl/lcd_host_command_unit.sv
// Host command decoder, cursor address counter and RAM sequencer of the LCD controller.
`timescale 1ns/1ps
module lcd_host_command_unit import lcd_host_command_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic host_e,
	input wire logic register_select,
	input wire logic host_rw,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe,
	output logic busy,
	output logic [15:0] ram_addr,
	output logic [7:0] ram_wdata,
	output logic ram_we,
	output logic ram_re,
	input wire logic [7:0] ram_rdata,
	input wire logic graphic_mode,
	input wire logic cursor_enable,
	input wire logic [3:0] vertical_pitch,
	input wire logic [3:0] char_row,
	input wire logic cursor_here,
	input wire logic char_dot,
	output logic [3:0] cursor_row,
	output logic [15:0] start_address,
	output logic [15:0] cursor_address,
	output logic pixel_dot
);

	typedef struct packed {
		exec_st_t st;
		logic [1:0] wait_cnt;
		logic e_prev;
		logic [3:0] cmd;
		logic [3:0] row;
		logic [7:0] start_low;
		logic [7:0] start_high;
		logic [15:0] cur;
		logic [7:0] holding;
		logic [2:0] bit_index;
		logic bit_value;
		logic [7:0] dout;
		logic doe;
		logic busy;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
		logic [15:0] start;
		logic pixel;
	} state_t;

	state_t cur_ff;
	state_t nxt_ff;

	logic rise;
	logic data_wr;
	logic data_rd;
	logic cmd_wr;
	logic stat_rd;
	logic read_done;

	assign rise = host_e && !cur_ff.e_prev;
	assign cmd_wr = rise && register_select && !host_rw && !cur_ff.busy;
	assign stat_rd = rise && register_select && host_rw;
	assign data_wr = rise && !register_select && !host_rw && !cur_ff.busy;
	assign data_rd = rise && !register_select && host_rw;
	assign read_done = cur_ff.wait_cnt == RAM_READ_LAT - 2'h1;

	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.e_prev = host_e;
		nxt_ff.we = 1'b0;
		nxt_ff.re = 1'b0;
		if (!host_e) begin
			nxt_ff.doe = 1'b0;
		end
		// Command register takes the low data nibble; busy is left alone.
		if (cmd_wr) begin
			nxt_ff.cmd = host_data_in[CMD_FIELD_W-1:0];
		end
		// Status read answers whatever the busy state.
		if (stat_rd) begin
			nxt_ff.dout = 8'h00;
			nxt_ff.dout[BUSY_BIT_POS] = cur_ff.busy;
			nxt_ff.doe = 1'b1;
		end
		if (data_rd) begin
			// The holding register goes out first; after a cursor load it is stale.
			nxt_ff.dout = cur_ff.holding;
			nxt_ff.doe = 1'b1;
			if (!cur_ff.busy && cur_ff.cmd == CMD_RAM_READ) begin
				nxt_ff.addr = cur_ff.cur;
				nxt_ff.re = 1'b1;
				nxt_ff.wait_cnt = 2'h0;
				nxt_ff.st = ST_READ_WAIT;
			end
		end
		// Data writes carry out the latched command; busy writes are dropped.
		if (data_wr) begin
			unique case (cur_ff.cmd)
				CMD_CURSOR_ROW: begin
					nxt_ff.row = host_data_in[ROW_FIELD_W-1:0];
				end
				CMD_START_LOW: begin
					nxt_ff.start_low = host_data_in;
				end
				CMD_START_HIGH: begin
					nxt_ff.start_high = host_data_in;
				end
				CMD_CURSOR_LOW: begin
					nxt_ff.cur[7:0] = host_data_in;
					if (cur_ff.cur[7] && !host_data_in[7]) begin
						nxt_ff.cur[15:8] = cur_ff.cur[15:8] + 8'h01;
					end
				end
				CMD_CURSOR_HIGH: begin
					nxt_ff.cur[15:8] = host_data_in;
				end
				CMD_RAM_WRITE: begin
					nxt_ff.addr = cur_ff.cur;
					nxt_ff.wdata = host_data_in;
					nxt_ff.we = 1'b1;
					nxt_ff.st = ST_WRITE;
				end
				CMD_BIT_CLEAR, CMD_BIT_SET: begin
					nxt_ff.bit_index = host_data_in[BIT_INDEX_W-1:0];
					nxt_ff.bit_value = cur_ff.cmd == CMD_BIT_SET;
					nxt_ff.addr = cur_ff.cur;
					nxt_ff.re = 1'b1;
					nxt_ff.wait_cnt = 2'h0;
					nxt_ff.st = ST_BIT_WAIT;
				end
				default: begin
					// Unknown codes leave every register as it was.
				end
			endcase
		end
		unique case (cur_ff.st)
			ST_IDLE: begin
			end
			ST_WRITE: begin
				nxt_ff.cur = cur_ff.cur + 16'h0001;
				nxt_ff.st = ST_IDLE;
			end
			ST_READ_WAIT: begin
				nxt_ff.wait_cnt = cur_ff.wait_cnt + 2'h1;
				if (read_done) begin
					nxt_ff.holding = ram_rdata;
					nxt_ff.cur = cur_ff.cur + 16'h0001;
					nxt_ff.st = ST_IDLE;
				end
			end
			ST_BIT_WAIT: begin
				nxt_ff.wait_cnt = cur_ff.wait_cnt + 2'h1;
				if (read_done) begin
					nxt_ff.wdata = ram_rdata;
					nxt_ff.wdata[cur_ff.bit_index] = cur_ff.bit_value;
					nxt_ff.we = 1'b1;
					nxt_ff.st = ST_BIT_WRITE;
				end
			end
			ST_BIT_WRITE: begin
				nxt_ff.cur = cur_ff.cur + 16'h0001;
				nxt_ff.st = ST_IDLE;
			end
		endcase
		nxt_ff.busy = nxt_ff.st != ST_IDLE;
		// Character mode keeps only the low nibble of the high byte.
		if (graphic_mode) begin
			nxt_ff.start = {cur_ff.start_high, cur_ff.start_low};
		end else begin
			nxt_ff.start = {4'h0, cur_ff.start_high[3:0], cur_ff.start_low};
		end
		// The cursor covers the whole cell width on its row.
		if (cursor_enable && cursor_here && char_row == cur_ff.row
				&& cur_ff.row <= vertical_pitch) begin
			nxt_ff.pixel = 1'b1;
		end else begin
			nxt_ff.pixel = char_dot;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur_ff <= '0;
			cur_ff.st <= ST_IDLE;
			cur_ff.cmd <= RST_COMMAND;
			cur_ff.row <= RST_CURSOR_ROW;
			cur_ff.start_low <= RST_BYTE;
			cur_ff.start_high <= RST_BYTE;
			cur_ff.cur <= RST_ADDRESS;
			cur_ff.holding <= RST_BYTE;
			cur_ff.start <= RST_ADDRESS;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign host_data_out = cur_ff.dout;
	assign host_data_oe = cur_ff.doe;
	assign busy = cur_ff.busy;
	assign ram_addr = cur_ff.addr;
	assign ram_wdata = cur_ff.wdata;
	assign ram_we = cur_ff.we;
	assign ram_re = cur_ff.re;
	assign cursor_row = cur_ff.row;
	assign start_address = cur_ff.start;
	assign cursor_address = cur_ff.cur;
	assign pixel_dot = cur_ff.pixel;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_ram_write_go;
		data_wr && cur_ff.cmd == CMD_RAM_WRITE;
	endsequence

	sequence s_ram_read_go;
		data_rd && !cur_ff.busy && cur_ff.cmd == CMD_RAM_READ;
	endsequence

	sequence s_bit_go;
		data_wr && (cur_ff.cmd == CMD_BIT_CLEAR || cur_ff.cmd == CMD_BIT_SET);
	endsequence

	property p_busy_read;
		stat_rd |=> host_data_oe && host_data_out[BUSY_BIT_POS] == $past(cur_ff.busy)
			&& host_data_out[6:0] == 7'h00;
	endproperty
	a_busy_read: assert property (p_busy_read) else $error("busy read wrong");

	property p_cmd_keeps_busy;
		cmd_wr |=> !busy;
	endproperty
	a_cmd_keeps_busy: assert property (p_cmd_keeps_busy) else $error("command set busy");

	property p_busy_ignores;
		cur_ff.busy && rise && !host_rw |=> $stable(cur_ff.cmd) && $stable(cursor_row);
	endproperty
	a_busy_ignores: assert property (p_busy_ignores) else $error("write taken busy");

	property p_ram_write;
		s_ram_write_go |=> ram_we && busy && ram_addr == $past(cursor_address)
			##1 !ram_we && cursor_address == $past(cursor_address, 2) + 16'h0001;
	endproperty
	a_ram_write: assert property (p_ram_write) else $error("ram write wrong");

	property p_ram_read;
		s_ram_read_go |=> host_data_out == $past(cur_ff.holding) && ram_re
			##2 cursor_address == $past(cursor_address, 3) + 16'h0001;
	endproperty
	a_ram_read: assert property (p_ram_read) else $error("ram read wrong");

	property p_low_carry;
		data_wr && cur_ff.cmd == CMD_CURSOR_LOW && cur_ff.cur[7] && !host_data_in[7]
			|=> cursor_address[15:8] == $past(cursor_address[15:8]) + 8'h01;
	endproperty
	a_low_carry: assert property (p_low_carry) else $error("no carry");

	property p_bit_seq;
		s_bit_go |-> ##3 ram_we ##1 (!ram_we
			&& cursor_address == $past(cursor_address, 4) + 16'h0001);
	endproperty
	a_bit_seq: assert property (p_bit_seq) else $error("bit op sequence wrong");

	property p_bit_value;
		ram_we && cur_ff.st == ST_BIT_WRITE |-> ram_wdata[cur_ff.bit_index] == cur_ff.bit_value;
	endproperty
	a_bit_value: assert property (p_bit_value) else $error("bit value wrong");

	property p_start_char;
		!graphic_mode |=> start_address[15:12] == 4'h0
			&& start_address[11:0] == $past({cur_ff.start_high[3:0], cur_ff.start_low});
	endproperty
	a_start_char: assert property (p_start_char) else $error("start address wrong");

	property p_no_cursor;
		cur_ff.row > vertical_pitch |=> pixel_dot == $past(char_dot);
	endproperty
	a_no_cursor: assert property (p_no_cursor) else $error("cursor shown");

	property p_cursor_wins;
		cursor_enable && cursor_here && char_row == cur_ff.row
			&& cur_ff.row <= vertical_pitch |=> pixel_dot;
	endproperty
	a_cursor_wins: assert property (p_cursor_wins) else $error("cursor hidden");

	property p_cmd_latch;
		cmd_wr |=> cur_ff.cmd == $past(host_data_in[CMD_FIELD_W-1:0]);
	endproperty
	a_cmd_latch: assert property (p_cmd_latch) else $error("command not latched");

	property p_row_load;
		data_wr && cur_ff.cmd == CMD_CURSOR_ROW |=> cursor_row == $past(host_data_in[3:0]);
	endproperty
	a_row_load: assert property (p_row_load) else $error("cursor row not loaded");

	property p_high_load;
		data_wr && cur_ff.cmd == CMD_CURSOR_HIGH
			|=> cursor_address == {$past(host_data_in), $past(cursor_address[7:0])};
	endproperty
	a_high_load: assert property (p_high_load) else $error("high byte not loaded");

	property p_start_graphic;
		graphic_mode |=> start_address == $past({cur_ff.start_high, cur_ff.start_low});
	endproperty
	a_start_graphic: assert property (p_start_graphic) else $error("start wrong");

	property p_bit_read;
		s_bit_go |=> ram_re && busy && ram_addr == $past(cursor_address);
	endproperty
	a_bit_read: assert property (p_bit_read) else $error("bit op read wrong");

	property p_read_refill;
		s_ram_read_go |-> ##3 cur_ff.holding == $past(ram_rdata);
	endproperty
	a_read_refill: assert property (p_read_refill) else $error("holding not refilled");

	property p_busy_ends;
		$rose(busy) |-> ##[1:3] !busy;
	endproperty
	a_busy_ends: assert property (p_busy_ends) else $error("busy never cleared");

	property p_status_quiet;
		stat_rd && !cur_ff.busy |=> !busy && !ram_re && !ram_we;
	endproperty
	a_status_quiet: assert property (p_status_quiet) else $error("status read acted");

	property p_read_refused;
		data_rd && !cur_ff.busy && cur_ff.cmd != CMD_RAM_READ
			|=> !ram_re && !busy && host_data_out == $past(cur_ff.holding);
	endproperty
	a_read_refused: assert property (p_read_refused) else $error("plain read acted");

	property p_oe_release;
		!host_e |=> !host_data_oe;
	endproperty
	a_oe_release: assert property (p_oe_release) else $error("bus still driven");

	property p_write_data;
		s_ram_write_go |=> ram_wdata == $past(host_data_in);
	endproperty
	a_write_data: assert property (p_write_data) else $error("write data wrong");

endmodule : lcd_host_command_unit

// ### bench/display_ram_model.sv
// Behavioural byte-wide display RAM on the far side of the command unit.
`timescale 1ns/1ps
module display_ram_model (
	input wire logic clk,
	input wire logic [15:0] ram_addr,
	input wire logic [7:0] ram_wdata,
	input wire logic ram_we,
	input wire logic ram_re,
	output logic [7:0] ram_rdata
);
	logic [7:0] mem [0:65535];
	initial ram_rdata = 8'h00;
	// Cleared so that reads beyond the written range return known data.
	initial foreach (mem[i]) mem[i] = 8'h00;
	// Read data is valid one cycle only; after that it toggles so a late sample is caught.
	always @(posedge clk) begin
		if (ram_we) mem[ram_addr] <= ram_wdata;
		ram_rdata <= ram_re ? mem[ram_addr] : ~ram_rdata;
	end
endmodule : display_ram_model

// ### bench/lcd_host_command_unit_tb.sv
// Self-checking bench of the LCD host command unit.
`timescale 1ns/1ps
`define CHK(w, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %s exp %h got %h", w, e, g); end end
module lcd_host_command_unit_tb import lcd_host_command_pkg::*; ();
	logic clk = 0, rst = 1, host_e = 0, register_select = 0, host_rw = 0, graphic_mode = 1;
	logic cursor_enable = 0, cursor_here = 0, char_dot = 0, oe_prev = 0;
	logic [7:0] host_data_in = 0, host_data_out, ram_wdata, ram_rdata, r;
	logic [3:0] vertical_pitch = 0, char_row = 0, cursor_row;
	logic [15:0] ram_addr, start_address, cursor_address;
	logic host_data_oe, busy, ram_we, ram_re, pixel_dot;
	logic [31:0] seed = 32'h599f9027;
	logic [7:0] sh [0:7];
	logic [7:0] rq [$];
	logic [23:0] wq [$];
	logic [23:0] w;
	int checked = 0, n_fail = 0, cyc = 0;
	always #2 clk = ~clk;
	lcd_host_command_unit lcd_host_command_unit_inst (.clk(clk), .rst(rst), .host_e(host_e),
		.register_select(register_select), .host_rw(host_rw), .host_data_in(host_data_in),
		.host_data_out(host_data_out), .host_data_oe(host_data_oe), .busy(busy),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re),
		.ram_rdata(ram_rdata), .graphic_mode(graphic_mode), .cursor_enable(cursor_enable),
		.vertical_pitch(vertical_pitch), .char_row(char_row), .cursor_here(cursor_here),
		.char_dot(char_dot), .cursor_row(cursor_row), .start_address(start_address),
		.cursor_address(cursor_address), .pixel_dot(pixel_dot));
	display_ram_model display_ram_model_inst (.clk(clk), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	task automatic acc(input logic rs, input logic rw, input logic [7:0] d);
		@(negedge clk);
		register_select = rs;
		host_rw = rw;
		host_data_in = d;
		host_e = 1;
		@(negedge clk);
		host_e = 0;
		@(negedge clk);
	endtask : acc
	task automatic idle();
		for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk);
	endtask : idle
	task automatic rd(input logic rs, input logic [7:0] e);
		rq.push_back(e);
		acc(rs, 1, 8'h00);
	endtask : rd
	task automatic cmd(input logic [3:0] c, input logic [7:0] d);
		acc(1, 0, {4'h0, c});
		`CHK("busy after command", 1'b0, busy)
		acc(0, 0, d);
		idle();
	endtask : cmd
	task automatic load(input logic [7:0] lo, input logic [7:0] hi);
		cmd(CMD_CURSOR_LOW, lo);
		cmd(CMD_CURSOR_HIGH, hi);
	endtask : load
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			print_verdict();
		end
	end
	// Every read answer and every RAM write must match the oldest note of its kind.
	always @(negedge clk) begin
		if (host_data_oe === 1'b1 && !oe_prev) begin
			r = rq.size() ? rq.pop_front() : 8'hxx;
			`CHK("host read", r, host_data_out)
		end
		if (ram_we === 1'b1) begin
			w = wq.size() ? wq.pop_front() : 24'hxxxxxx;
			`CHK("ram write", w, {ram_addr, ram_wdata})
		end
		oe_prev <= host_data_oe;
	end
	initial begin
		repeat (3) @(negedge clk);
		rst = 0;
		`CHK("reset cursor", 16'h0000, cursor_address)
		cmd(CMD_CURSOR_ROW, 8'h05);
		`CHK("cursor row", 4'h5, cursor_row)
		cmd(CMD_START_LOW, 8'ha5);
		cmd(CMD_START_HIGH, 8'h3c);
		`CHK("start graphic", 16'h3ca5, start_address)
		graphic_mode = 0;
		@(negedge clk);
		`CHK("start char", 16'h0ca5, start_address)
		load(8'hff, 8'h12);
		`CHK("cursor", 16'h12ff, cursor_address)
		cmd(CMD_CURSOR_LOW, 8'h10);
		`CHK("cursor carry", 16'h1310, cursor_address)
		cmd(CMD_CURSOR_HIGH, 8'h12);
		`CHK("cursor reload", 16'h1210, cursor_address)
		cmd(4'h1, 8'h3f);
		`CHK("unknown code row", 4'h5, cursor_row)
		`CHK("unknown code cursor", 16'h1210, cursor_address)
		rd(0, 8'h00);
		$display("test registers done");
		load(8'hfe, 8'h12);
		acc(1, 0, {4'h0, CMD_RAM_WRITE});
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			sh[i] = seed[7:0];
			wq.push_back({16'h12fe + 16'(i), sh[i]});
			acc(0, 0, sh[i]);
			idle();
		end
		`CHK("cursor after write", 16'h1306, cursor_address)
		load(8'hfe, 8'h12);
		acc(1, 0, {4'h0, CMD_RAM_READ});
		for (int i = -1; i < 8; i++) begin
			rd(0, i < 0 ? 8'h00 : sh[i]);
			idle();
		end
		`CHK("cursor after read", 16'h1307, cursor_address)
		rd(1, 8'h00);
		$display("test ram done");
		load(8'hfe, 8'h12);
		for (int i = 0; i < 8; i++) begin
			sh[i][i] = i[0];
			wq.push_back({16'h12fe + 16'(i), sh[i]});
			cmd(i[0] ? CMD_BIT_SET : CMD_BIT_CLEAR, 8'(i));
		end
		`CHK("cursor after bits", 16'h1306, cursor_address)
		load(8'hfe, 8'h12);
		sh[0][7] = 1'b1;
		sh[1][6] = 1'b1;
		wq.push_back({16'h12fe, sh[0]});
		wq.push_back({16'h12ff, sh[1]});
		acc(1, 0, {4'h0, CMD_BIT_SET});
		acc(0, 0, 8'h07);
		acc(0, 0, 8'h00);
		idle();
		`CHK("cursor after refusal", 16'h12ff, cursor_address)
		acc(0, 0, 8'h06);
		rd(1, 8'h80);
		idle();
		$display("test bits done");
		for (int i = 0; i < 64; i++) begin
			seed = lfsr(seed);
			{cursor_enable, cursor_here, char_dot, vertical_pitch} = seed[6:0];
			char_row = seed[7] ? 4'h5 : seed[11:8];
			@(negedge clk);
			`CHK("pixel", (cursor_enable & cursor_here & (char_row == 4'h5) &
				(vertical_pitch >= 4'h5)) | char_dot, pixel_dot)
		end
		$display("test display done");
		print_verdict();
	end
endmodule : lcd_host_command_unit_tb
